//--- rtl/safety_pkg.sv
// Purpose: shared constants and types for the safety io mode supervisor
// Assumes: 200 MHz core clock
// Notes: none
// Functional notes
// - every safety input and output is carried on two redundant channels
// - emergency stop halts motion, stops program, removes power, category 1
// - safeguard stop halts motion as category 2, power on, program paused
// - auto reset: motion resumes by itself once safeguard stop releases
// - manual reset: after release stay paused until a reset pulse arrives
// - response to safeguard stop and reduced mode up to 1200ms; overuse flags error
// - reduced mode input asserted limits joint and tool speed
// - reduced mode input released returns to normal limits
// - verification mode allows motion only in enabling middle position
// - verification mode pauses at once when enabling becomes invalid
// - selector position a selects normal mode, enabling ignored, unless the software setting selects verification mode
// - selector position b selects verification mode, enabling gates motion
// - verification mode from software setting or selector, either suffices
// - reset input counts as restart only with manual reset configured
// - eight dual-channel status outputs are provided
// - estop normally closed output is always inverse of normally open
// - not stopping output holds from stop request until motion ceases
// - system stop input acts exactly like emergency stop, category 1
// - moving output asserted only while moving normally
`default_nettype none
package safety_pkg;
  localparam int unsigned clk_mhz = 200;
  localparam int unsigned response_ms = 1200;
  localparam int unsigned response_cycles = response_ms * 1000 * clk_mhz;
  localparam int unsigned disagree_ms = 50;
  localparam int unsigned disagree_cycles = disagree_ms * 1000 * clk_mhz;
  localparam int unsigned trigger_limit = 8;
  localparam int unsigned num_inputs = 8;
  typedef enum logic [2:0] {
    st_idle     = 3'b000,
    st_run      = 3'b001,
    st_decel    = 3'b010,
    st_paused   = 3'b011,
    st_estopped = 3'b100
  } motion_state_t;
  typedef enum logic [1:0] {
    stop_none = 2'b00,
    stop_cat1 = 2'b01,
    stop_cat2 = 2'b10
  } stop_cat_t;
endpackage
`default_nettype wire

//--- rtl/dual_channel_check.sv
// Purpose: merge two redundant input channels, flag lasting disagreement
// Assumes: inputs synchronous to core_clk, active high
// Notes: disagreement reads as asserted, the safe side
`timescale 1ns/1ps
`default_nettype none
module dual_channel_check #(
  parameter int unsigned width = 8,
  parameter int unsigned limit = 100
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // channels
  input wire logic [width-1:0] chan_a,
  input wire logic [width-1:0] chan_b,
  // merged
  output logic [width-1:0] merged,
  output logic fault
);
  initial begin
    if (width < 1 || limit < 1) begin
      $error("dual_channel_check: bad parameters");
    end
  end
  typedef struct packed {
    logic [31:0] cnt;
    logic [width-1:0] merged;
    logic fault;
  } state_t;
  state_t state_reg;
  state_t state_next;
  always_comb begin
    state_next = state_reg;
    state_next.merged = chan_a | chan_b;
    if (chan_a != chan_b) begin
      // short skew between contacts is normal, so only a lasting split is a fault
      if (state_reg.cnt < limit) begin
        state_next.cnt = state_reg.cnt + 32'h1;
      end else begin
        state_next.fault = 1'b1;
      end
    end else begin
      state_next.cnt = 32'h0;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
  assign merged = state_reg.merged;
  assign fault = state_reg.fault;
endmodule
`default_nettype wire

//--- rtl/safety_io_mode_supervisor.sv
// Purpose: safety input supervisor deciding stop, mode and status outputs
// Assumes: all inputs synchronous to core_clk, active high
// Notes: fault latches until reset; long counts are parameters
`timescale 1ns/1ps
`default_nettype none
module safety_io_mode_supervisor #(
  parameter int unsigned response_cycles = safety_pkg::response_cycles,
  parameter int unsigned disagree_cycles = safety_pkg::disagree_cycles,
  parameter int unsigned trigger_limit = safety_pkg::trigger_limit
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // safety inputs, two channels each
  input wire logic estop_in_a,
  input wire logic estop_in_b,
  input wire logic safeguard_stop_in_a,
  input wire logic safeguard_stop_in_b,
  input wire logic reduced_mode_in_a,
  input wire logic reduced_mode_in_b,
  input wire logic safeguard_reset_in_a,
  input wire logic safeguard_reset_in_b,
  input wire logic enabling_device_in_a,
  input wire logic enabling_device_in_b,
  input wire logic op_mode_sel_in_a,
  input wire logic op_mode_sel_in_b,
  input wire logic force_ctrl_en_in_a,
  input wire logic force_ctrl_en_in_b,
  input wire logic system_stop_in_a,
  input wire logic system_stop_in_b,
  // configuration and controller side
  input wire logic manual_reset_cfg,
  input wire logic verify_mode_cfg,
  input wire logic run_request,
  input wire logic motion_stopped,
  input wire logic software_running,
  // motion control
  output logic motion_permit,
  output logic program_paused,
  output logic program_stopped,
  output logic robot_power_on,
  output logic speed_limit_reduced,
  output logic verify_mode,
  output logic force_ctrl_en,
  output logic [1:0] stop_category,
  // status outputs, two channels each
  output logic estop_no_out_a,
  output logic estop_no_out_b,
  output logic moving_out_a,
  output logic moving_out_b,
  output logic not_stopping_out_a,
  output logic not_stopping_out_b,
  output logic reduced_out_a,
  output logic reduced_out_b,
  output logic non_reduced_out_a,
  output logic non_reduced_out_b,
  output logic sys_error_out_a,
  output logic sys_error_out_b,
  output logic estop_nc_out_a,
  output logic estop_nc_out_b,
  output logic running_out_a,
  output logic running_out_b
);
  initial begin
    // trigger count register is eight bits wide
    if (response_cycles < 1 || disagree_cycles < 1 || trigger_limit < 1
      || trigger_limit > 32'hff) begin
      $error("safety_io_mode_supervisor: bad parameters");
    end
  end

  logic [7:0] in_a;
  logic [7:0] in_b;
  logic [7:0] in_m;
  logic chan_fault;
  // merge of both channels
  assign in_a = {system_stop_in_a, force_ctrl_en_in_a, op_mode_sel_in_a,
    enabling_device_in_a, safeguard_reset_in_a, reduced_mode_in_a,
    safeguard_stop_in_a, estop_in_a};
  assign in_b = {system_stop_in_b, force_ctrl_en_in_b, op_mode_sel_in_b,
    enabling_device_in_b, safeguard_reset_in_b, reduced_mode_in_b,
    safeguard_stop_in_b, estop_in_b};

  dual_channel_check #(
    .width(safety_pkg::num_inputs),
    .limit(disagree_cycles)
  ) dual_channel_check_i (
    .core_clk(core_clk),
    .resetn(resetn),
    .chan_a(in_a),
    .chan_b(in_b),
    .merged(in_m),
    .fault(chan_fault)
  );

  logic estop;
  logic sg_stop;
  logic reduced_in;
  logic reset_in;
  logic enable_ok;
  logic sel_b;
  assign estop = in_m[0] | in_m[7];
  assign sg_stop = in_m[1];
  assign reduced_in = in_m[2];
  assign reset_in = in_m[3];
  assign enable_ok = in_m[4];
  assign sel_b = in_m[5];

  typedef struct packed {
    safety_pkg::motion_state_t mst;
    logic reset_prev;
    logic reset_armed;
    logic sg_prev;
    logic red_prev;
    logic reduced;
    logic [31:0] win_cnt;
    logic [7:0] trig_cnt;
    logic trig_fault;
    logic [1:0] cat;
    logic power;
    logic prog_stop;
    logic moving;
    logic not_stopping;
    logic verify;
    logic force_en;
  } state_t;
  state_t s_reg;
  state_t s_next;

  logic verify_now;
  logic gate_ok;
  logic reset_pulse;
  assign verify_now = verify_mode_cfg | sel_b;
  // selector at a with verify_mode_cfg low leaves enabling out of the gate
  assign gate_ok = !verify_now || enable_ok;
  assign reset_pulse = reset_in && !s_reg.reset_prev;

  always_comb begin
    s_next = s_reg;
    s_next.reset_prev = reset_in;
    s_next.sg_prev = sg_stop;
    s_next.red_prev = reduced_in;
    s_next.verify = verify_now;
    s_next.force_en = in_m[6];
    s_next.reduced = reduced_in;
    // frequent triggering within one response window is flagged
    if (s_reg.win_cnt >= response_cycles - 1) begin
      s_next.win_cnt = 32'h0;
      s_next.trig_cnt = 8'h0;
    end else begin
      s_next.win_cnt = s_reg.win_cnt + 32'h1;
    end
    if ((sg_stop && !s_reg.sg_prev) || (reduced_in != s_reg.red_prev)) begin
      if ({24'h0, s_reg.trig_cnt} >= trigger_limit) begin
        s_next.trig_fault = 1'b1;
      end else begin
        s_next.trig_cnt = s_reg.trig_cnt + 8'h1;
      end
    end
    unique case (s_reg.mst)
      safety_pkg::st_idle: begin
        if (estop) begin
          s_next.mst = safety_pkg::st_estopped;
        end else if (run_request && gate_ok && !sg_stop) begin
          s_next.mst = safety_pkg::st_run;
        end
      end
      safety_pkg::st_run: begin
        // no wait for the move to finish
        if (estop || sg_stop || !gate_ok) begin
          s_next.mst = safety_pkg::st_decel;
        end else if (!run_request) begin
          s_next.mst = safety_pkg::st_idle;
        end
      end
      safety_pkg::st_decel: begin
        if (motion_stopped) begin
          s_next.mst = estop ? safety_pkg::st_estopped : safety_pkg::st_paused;
        end
      end
      safety_pkg::st_paused: begin
        if (estop) begin
          s_next.mst = safety_pkg::st_estopped;
        end else if (!sg_stop && gate_ok) begin
          // reset only matters in manual mode
          if (!manual_reset_cfg) begin
            s_next.mst = safety_pkg::st_run;
          end else if (s_reg.reset_armed || reset_pulse) begin
            s_next.mst = safety_pkg::st_run;
          end
        end
      end
      safety_pkg::st_estopped: begin
        if (!estop && !run_request) begin
          s_next.mst = safety_pkg::st_idle;
        end
      end
      default: s_next.mst = safety_pkg::st_estopped;
    endcase
    // a reset pressed while still stopped is not kept; press after clearing
    s_next.reset_armed = manual_reset_cfg && !sg_stop && s_reg.mst == safety_pkg::st_paused
      && (s_reg.reset_armed || reset_pulse) && !gate_ok;
    if (estop) begin
      s_next.cat = safety_pkg::stop_cat1;
      s_next.power = 1'b0;
      s_next.prog_stop = 1'b1;
    end else if (sg_stop || s_next.mst == safety_pkg::st_paused) begin
      s_next.cat = safety_pkg::stop_cat2;
      s_next.power = 1'b1;
      s_next.prog_stop = s_reg.prog_stop && s_next.mst != safety_pkg::st_run;
    end else begin
      s_next.cat = safety_pkg::stop_none;
      s_next.power = 1'b1;
      s_next.prog_stop = s_reg.prog_stop && s_next.mst != safety_pkg::st_run;
    end
    s_next.moving = s_next.mst == safety_pkg::st_run;
    s_next.not_stopping = s_next.mst == safety_pkg::st_decel;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '{mst: safety_pkg::st_idle, power: 1'b1, prog_stop: 1'b1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  logic stopping_prog_pause;
  assign stopping_prog_pause = s_reg.mst == safety_pkg::st_paused
    || (s_reg.mst == safety_pkg::st_decel && s_reg.cat == safety_pkg::stop_cat2);
  assign motion_permit = s_reg.moving;
  assign program_paused = stopping_prog_pause;
  assign program_stopped = s_reg.prog_stop;
  assign robot_power_on = s_reg.power;
  assign speed_limit_reduced = s_reg.reduced;
  assign verify_mode = s_reg.verify;
  assign force_ctrl_en = s_reg.force_en;
  assign stop_category = s_reg.cat;
  // both channels driven alike
  assign estop_no_out_a = s_reg.cat == safety_pkg::stop_cat1;
  assign estop_no_out_b = s_reg.cat == safety_pkg::stop_cat1;
  assign estop_nc_out_a = !estop_no_out_a;
  assign estop_nc_out_b = !estop_no_out_b;
  assign moving_out_a = s_reg.moving;
  assign moving_out_b = s_reg.moving;
  assign not_stopping_out_a = s_reg.not_stopping;
  assign not_stopping_out_b = s_reg.not_stopping;
  assign reduced_out_a = s_reg.reduced;
  assign reduced_out_b = s_reg.reduced;
  assign non_reduced_out_a = !s_reg.reduced;
  assign non_reduced_out_b = !s_reg.reduced;
  assign sys_error_out_a = chan_fault | s_reg.trig_fault;
  assign sys_error_out_b = chan_fault | s_reg.trig_fault;
  assign running_out_a = software_running;
  assign running_out_b = software_running;
endmodule
`default_nettype wire

//--- verif/switch_panel.sv
// Purpose: dual-channel switch panel standing in front of the supervisor
// Assumes: one bit per safety function, level driven
// Notes: cut_b holds channel b open to mimic one broken contact
`timescale 1ns/1ps
`default_nettype none
module switch_panel (
  // operator levels
  input wire logic [7:0] press,
  input wire logic [7:0] cut_b,
  // contact channels
  output logic [7:0] chan_a,
  output logic [7:0] chan_b
);
  // both contacts follow one actuator
  assign chan_a = press;
  // a broken contact reads released, the unsafe side
  assign chan_b = press & ~cut_b;
endmodule
`default_nettype wire

//--- verif/safety_sup_sva.sv
// Purpose: port-level checks for the safety supervisor
// Assumes: single core_clk domain
// Notes: outputs lag the pins by two clock edges; system stop counts as estop
`timescale 1ns/1ps
`default_nettype none
module safety_sup_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // safety inputs
  input wire logic estop_in_a,
  input wire logic estop_in_b,
  input wire logic safeguard_stop_in_a,
  input wire logic safeguard_stop_in_b,
  input wire logic reduced_mode_in_a,
  input wire logic reduced_mode_in_b,
  input wire logic enabling_device_in_a,
  input wire logic enabling_device_in_b,
  input wire logic system_stop_in_a,
  input wire logic system_stop_in_b,
  // controller side
  input wire logic verify_mode_cfg,
  input wire logic motion_stopped,
  input wire logic software_running,
  input wire logic motion_permit,
  input wire logic robot_power_on,
  input wire logic speed_limit_reduced,
  input wire logic verify_mode,
  input wire logic [1:0] stop_category,
  // status outputs
  input wire logic estop_no_out_a,
  input wire logic estop_no_out_b,
  input wire logic estop_nc_out_a,
  input wire logic moving_out_a,
  input wire logic moving_out_b,
  input wire logic not_stopping_out_a,
  input wire logic reduced_out_a,
  input wire logic non_reduced_out_a,
  input wire logic sys_error_out_a,
  input wire logic sys_error_out_b,
  input wire logic running_out_a
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // system stop is folded in, it must act exactly as an estop
  wire logic es = estop_in_a | estop_in_b | system_stop_in_a | system_stop_in_b;
  wire logic sg = safeguard_stop_in_a | safeguard_stop_in_b;
  wire logic rd = reduced_mode_in_a | reduced_mode_in_b;
  wire logic en = enabling_device_in_a | enabling_device_in_b;
  chk_pair_equal: assert property (
    {moving_out_a, estop_no_out_a, sys_error_out_a} ==
    {moving_out_b, estop_no_out_b, sys_error_out_b}) else $error("status pair differs");
  chk_estop_cat1: assert property ($rose(es) |-> ##2
    (stop_category == 2'h1 && !robot_power_on)) else $error("estop not category 1");
  chk_sg_cat2: assert property (moving_out_a && !es && $rose(sg) |-> ##2
    (stop_category == 2'h2 && robot_power_on)) else $error("safeguard not category 2");
  chk_nc_inverse: assert property (estop_nc_out_a != estop_no_out_a)
    else $error("estop nc not inverse of no");
  chk_decel_hold: assert property (not_stopping_out_a && !motion_stopped |=>
    not_stopping_out_a) else $error("not stopping dropped early");
  chk_moving_clean: assert property (moving_out_a |-> motion_permit &&
    !not_stopping_out_a) else $error("moving while stopping");
  chk_reduced_on: assert property (rd [*3] |-> speed_limit_reduced &&
    reduced_out_a && !non_reduced_out_a) else $error("reduced mode missing");
  chk_reduced_off: assert property (!rd [*3] |-> !speed_limit_reduced &&
    non_reduced_out_a) else $error("reduced mode stuck");
  chk_verify_gate: assert property ((verify_mode && !en) [*3] |-> !moving_out_a)
    else $error("moving without enabling");
  chk_verify_cfg: assert property (verify_mode_cfg [*3] |-> verify_mode)
    else $error("software verify ignored");
  chk_error_sticky: assert property (sys_error_out_a |=> sys_error_out_a)
    else $error("system error cleared");
  chk_running_pass: assert property (running_out_a == software_running)
    else $error("running output wrong");
  cover property ($rose(not_stopping_out_a));
  cover property ($rose(sys_error_out_a));
  cover property ($fell(moving_out_a) && verify_mode);
endmodule
bind safety_io_mode_supervisor safety_sup_sva safety_sup_sva_i (.core_clk, .resetn,
  .estop_in_a, .estop_in_b, .safeguard_stop_in_a, .safeguard_stop_in_b, .reduced_mode_in_a,
  .reduced_mode_in_b, .enabling_device_in_a, .enabling_device_in_b, .system_stop_in_a,
  .system_stop_in_b, .verify_mode_cfg, .motion_stopped, .software_running, .motion_permit,
  .robot_power_on, .speed_limit_reduced, .verify_mode, .stop_category, .estop_no_out_a,
  .estop_no_out_b, .estop_nc_out_a, .moving_out_a, .moving_out_b, .not_stopping_out_a,
  .reduced_out_a, .non_reduced_out_a, .sys_error_out_a, .sys_error_out_b, .running_out_a);
`default_nettype wire

//--- verif/tb_safety_io_mode_supervisor.sv
// Purpose: directed bench for the safety supervisor
// Assumes: counts shortened through parameters
// Notes: inputs move on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_safety_io_mode_supervisor;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] press = 8'h00;
  logic [7:0] cut_b = 8'h00;
  logic [7:0] ca, cb;
  logic man = 1'b0, vcfg = 1'b0, runq = 1'b0, mstop = 1'b0, swr = 1'b0;
  logic mp, pp, ps, pw, sl, vm, fce;
  logic [1:0] cat;
  logic eno_a, eno_b, mv_a, mv_b, ns_a, ns_b, rd_a, rd_b;
  logic nr_a, nr_b, se_a, se_b, nc_a, nc_b, ru_a, ru_b;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  always #2.5 core_clk = ~core_clk;
  switch_panel switch_panel_i (.press(press), .cut_b(cut_b), .chan_a(ca), .chan_b(cb));
  safety_io_mode_supervisor #(.response_cycles(50), .disagree_cycles(4), .trigger_limit(8))
    safety_io_mode_supervisor_i (.core_clk(core_clk), .resetn(resetn),
    .estop_in_a(ca[0]), .estop_in_b(cb[0]), .safeguard_stop_in_a(ca[1]),
    .safeguard_stop_in_b(cb[1]), .reduced_mode_in_a(ca[2]), .reduced_mode_in_b(cb[2]),
    .safeguard_reset_in_a(ca[3]), .safeguard_reset_in_b(cb[3]),
    .enabling_device_in_a(ca[4]), .enabling_device_in_b(cb[4]), .op_mode_sel_in_a(ca[5]),
    .op_mode_sel_in_b(cb[5]), .force_ctrl_en_in_a(ca[6]), .force_ctrl_en_in_b(cb[6]),
    .system_stop_in_a(ca[7]), .system_stop_in_b(cb[7]), .manual_reset_cfg(man),
    .verify_mode_cfg(vcfg), .run_request(runq), .motion_stopped(mstop),
    .software_running(swr), .motion_permit(mp), .program_paused(pp), .program_stopped(ps),
    .robot_power_on(pw), .speed_limit_reduced(sl), .verify_mode(vm), .force_ctrl_en(fce),
    .stop_category(cat), .estop_no_out_a(eno_a), .estop_no_out_b(eno_b),
    .moving_out_a(mv_a), .moving_out_b(mv_b), .not_stopping_out_a(ns_a),
    .not_stopping_out_b(ns_b), .reduced_out_a(rd_a), .reduced_out_b(rd_b),
    .non_reduced_out_a(nr_a), .non_reduced_out_b(nr_b), .sys_error_out_a(se_a),
    .sys_error_out_b(se_b), .estop_nc_out_a(nc_a), .estop_nc_out_b(nc_b),
    .running_out_a(ru_a), .running_out_b(ru_b));
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [1:0] exp, input logic [1:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask
  task automatic restart();
    resetn = 1'b0;
    step(2);
    resetn = 1'b1;
    step(4);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // far above the directed sequence, which needs about 125 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    step(2);
    resetn = 1'b1;
    step(1);
    chk("estop_nc", 2'h3, {nc_a, nc_b});
    chk("non_reduced", 2'h3, {nr_a, nr_b});
    swr = 1'b1;
    runq = 1'b1;
    step(4);
    chk("running", 2'h3, {ru_a, ru_b});
    chk("moving", 2'h3, {mv_a, mv_b});
    chk("permit", 2'h3, {mp, ps == 1'b0});
    press[1] = 1'b1;
    step(3);
    chk("not_stopping", 2'h3, {ns_a, ns_b});
    chk("moving", 2'h0, {mv_a, mv_b});
    chk("cat2_power", 2'h3, {cat == 2'h2, pw});
    chk("paused", 2'h1, {1'b0, pp});
    mstop = 1'b1;
    step(2);
    chk("not_stopping", 2'h0, {ns_a, ns_b});
    press[1] = 1'b0;
    mstop = 1'b0;
    step(4);
    chk("auto_resume", 2'h3, {mv_a, mv_b});
    man = 1'b1;
    press[1] = 1'b1;
    mstop = 1'b1;
    step(4);
    // a press while the zone is still guarded must be dropped
    press[3] = 1'b1;
    step(1);
    press[3] = 1'b0;
    step(1);
    press[1] = 1'b0;
    step(6);
    chk("manual_hold", 2'h1, {mv_a, pp});
    // button pressed only once the zone is clear
    press[3] = 1'b1;
    step(1);
    press[3] = 1'b0;
    mstop = 1'b0;
    step(4);
    chk("manual_resume", 2'h3, {mv_a, mv_b});
    press[2] = 1'b1;
    step(3);
    chk("reduced", 2'h3, {rd_a, rd_b});
    chk("limits", 2'h1, {nr_a, sl});
    press[2] = 1'b0;
    step(3);
    chk("non_reduced", 2'h3, {nr_a, nr_b});
    chk("limits", 2'h0, {rd_a, sl});
    press[4] = 1'b1;
    press[5] = 1'b1;
    step(3);
    chk("verify_sel", 2'h3, {vm, mv_a});
    press[4] = 1'b0;
    step(3);
    chk("enable_lost", 2'h1, {mv_a, ns_a});
    press[5] = 1'b0;
    press[4] = 1'b1;
    restart();
    vcfg = 1'b1;
    step(3);
    chk("verify_cfg", 2'h3, {vm, mv_a});
    press[4] = 1'b0;
    step(3);
    chk("enable_lost", 2'h0, {mv_a, mv_b});
    vcfg = 1'b0;
    // emergency stop, then system stop, must look the same
    for (int i = 0; i < 8; i += 7) begin
      restart();
      press[i] = 1'b1;
      mstop = 1'b1;
      step(4);
      chk("estop_no", 2'h3, {eno_a, eno_b});
      chk("estop_nc", 2'h0, {nc_a, nc_b});
      chk("power_prog", 2'h1, {pw, ps});
      chk("cat1", 2'h1, cat);
      press[i] = 1'b0;
      mstop = 1'b0;
    end
    man = 1'b0;
    restart();
    for (int i = 0; i < 10; i++) begin
      press[1] = 1'b1;
      step(1);
      press[1] = 1'b0;
      step(1);
    end
    step(3);
    chk("overuse_error", 2'h3, {se_a, se_b});
    restart();
    press[6] = 1'b1;
    cut_b[2] = 1'b1;
    press[2] = 1'b1;
    step(8);
    chk("force_ctrl", 2'h1, {1'b0, fce});
    chk("mismatch", 2'h3, {se_a, se_b});
    chk("mismatch_on", 2'h3, {rd_a, sl});
    press[2] = 1'b0;
    cut_b[2] = 1'b0;
    step(4);
    chk("error_sticky", 2'h3, {se_a, se_b});
    give_verdict();
  end
endmodule
`default_nettype wire
